// *** include/ps_defines.svh ***
// Address map, vectors and timing constants of the program sequencer
`ifndef PS_DEFINES_SVH
`define PS_DEFINES_SVH

// ****************************************
// Data memory locations
// ****************************************
`define PS_ADDR_INDIRECT   7'h00
`define PS_ADDR_MEM_PTR    7'h01
`define PS_ADDR_WORK_REG   7'h05
`define PS_ADDR_CNT_LOW    7'h06
`define PS_ADDR_TBL_PTR    7'h07
`define PS_ADDR_TBL_UPPER  7'h08
`define PS_ADDR_GP_BASE    7'h40

// ****************************************
// Program memory vectors and pages
// ****************************************
`define PS_VEC_RESET       11'h000
`define PS_VEC_EXT         11'h004
`define PS_VEC_TMR         11'h008
`define PS_VEC_ADC         11'h00c
`define PS_LAST_PAGE       3'h7

// ****************************************
// Timing and sizes
// ****************************************
`define PS_CLKS_PER_CYCLE  4
`define PS_PHASE_LAST      2'h3
`define PS_STACK_DEPTH     6
`define PS_PC_WIDTH        11
`define PS_PTR_TOP_READ    1'b1

`endif

// *** include/ps_pkg.sv ***
// Types shared by the program sequencer files
`default_nettype none
package ps_pkg;

   typedef enum logic [2:0] {
      PS_CMD_NONE, PS_CMD_SKIP, PS_CMD_JUMP, PS_CMD_CALL,
      PS_CMD_SUB_EXIT, PS_CMD_INT_EXIT, PS_CMD_TBL_CUR, PS_CMD_TBL_LAST
   } ps_cmd_type;

   typedef enum logic [1:0] {
      PS_DM_NONE, PS_DM_WRITE, PS_DM_BIT_SET, PS_DM_BIT_CLEAR
   } ps_dm_op_type;

   typedef struct packed {
      ps_cmd_type   cmd;
      ps_dm_op_type dm_op;
      logic [6:0]   dm_addr;
      logic [2:0]   dm_bit;
      logic [7:0]   dm_wdata;
   } ps_req_type;

   typedef enum logic [2:0] {
      PS_SEQ_RUN   = 3'b001,
      PS_SEQ_DUMMY = 3'b010,
      PS_SEQ_TABLE = 3'b100
   } ps_seq_type;

   typedef struct packed {
      logic [1:0]      phase;
      ps_seq_type      seq;
      logic [10:0]     program_counter;
      logic [13:0]     ins;
      logic [6:0]      tbl_dst;
      logic            tbl_last;
      logic [6:0]      memory_pointer;
      logic [7:0]      working_register;
      logic [7:0]      table_address_pointer;
      logic [5:0]      table_upper_result;
      logic [63:0][7:0] ram;
      logic [2:0]      ack;
      logic            int_exit;
   } ps_core_state_type;

endpackage
`default_nettype wire

// *** core/ps_return_stack.sv ***
// Return address stack with oldest-entry drop on overflow
`default_nettype none
`include "ps_defines.svh"
module ps_return_stack import ps_pkg::*; #(
   parameter int DEPTH = `PS_STACK_DEPTH,
   parameter int WIDTH = `PS_PC_WIDTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top,
   output logic                  full
);

   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] ent;
      logic [CW-1:0]               level;
   } ps_stack_state_type;

   ps_stack_state_type st_reg;
   ps_stack_state_type st_next;

   // Shift register: a push while full pushes the oldest entry out the bottom
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.ent = {st_reg.ent[DEPTH-2:0], push_data};
         if (!full) begin
            st_next.level = st_reg.level + CW'(1);
         end
      end else if (pop) begin
         st_next.ent = {{WIDTH{1'b0}}, st_reg.ent[DEPTH-1:1]};
         if (st_reg.level != '0) begin
            st_next.level = st_reg.level - CW'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign top  = st_reg.ent[0];
   assign full = (st_reg.level == CW'(DEPTH));

endmodule // ps_return_stack
`default_nettype wire

// *** core/ps_sequencer.sv ***
// Program sequencer core: counter, stack, table read and data memory map
`default_nettype none
`include "ps_defines.svh"
module ps_sequencer import ps_pkg::*; #(
   parameter int STACK_DEPTH = `PS_STACK_DEPTH
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   output logic [10:0]      rom_addr,
   input  wire logic [13:0] rom_data,
   output logic [13:0]      exec_word,
   output logic             exec_valid,
   output logic             exec_last,
   input  wire ps_req_type  req,
   output logic [7:0]       dm_rdata,
   input  wire logic [2:0]  irq_req,
   output logic [2:0]       irq_ack,
   output logic             int_exit_pulse,
   output logic             stack_full,
   output logic [10:0]      program_counter
);

   // ****************************************
   // Helpers
   // ****************************************
   // Bit 7 flags a real target; indirect through a self-pointer has none
   function automatic logic [7:0] ps_resolve(logic [6:0] a, logic [6:0] ptr);
      if (a == `PS_ADDR_INDIRECT) begin
         ps_resolve = {(ptr != `PS_ADDR_INDIRECT), ptr};
      end else begin
         ps_resolve = {1'b1, a};
      end
   endfunction

   function automatic logic [7:0] ps_read(ps_core_state_type s, logic [7:0] e);
      ps_read = 8'h00;
      if (e[7]) begin
         if (e[6]) begin
            ps_read = s.ram[e[5:0]];
         end else begin
            unique case (e[6:0])
               `PS_ADDR_MEM_PTR:   ps_read = {`PS_PTR_TOP_READ, s.memory_pointer};
               `PS_ADDR_WORK_REG:  ps_read = s.working_register;
               `PS_ADDR_CNT_LOW:   ps_read = s.program_counter[7:0];
               `PS_ADDR_TBL_PTR:   ps_read = s.table_address_pointer;
               `PS_ADDR_TBL_UPPER: ps_read = {2'b00, s.table_upper_result};
               default:            ps_read = 8'h00;
            endcase
         end
      end
   endfunction

   // Counter low byte is handled by the caller since it also redirects fetch
   function automatic ps_core_state_type ps_write(ps_core_state_type s, logic [7:0] e,
                                                  logic [7:0] v);
      ps_write = s;
      if (e[7]) begin
         if (e[6]) begin
            ps_write.ram[e[5:0]] = v;
         end else begin
            unique case (e[6:0])
               `PS_ADDR_MEM_PTR:  ps_write.memory_pointer = v[6:0];
               `PS_ADDR_WORK_REG: ps_write.working_register = v;
               `PS_ADDR_TBL_PTR:  ps_write.table_address_pointer = v;
               default:           ps_write = s;
            endcase
         end
      end
   endfunction

   // ****************************************
   // State
   // ****************************************
   localparam ps_core_state_type RESET_STATE = '{
      phase: 2'h0, seq: PS_SEQ_DUMMY, program_counter: `PS_VEC_RESET,
      default: '0};

   ps_core_state_type st_reg;
   ps_core_state_type st_next;

   logic        last;
   logic        run_last;
   logic [7:0]  dm_eff;
   logic [7:0]  dm_cur;
   logic [7:0]  dm_new;
   logic        cnt_low_wr;
   logic        take_int;
   logic        stk_push;
   logic        stk_pop;
   logic [10:0] stk_top;

   assign last     = (st_reg.phase == `PS_PHASE_LAST);
   assign run_last = last && (st_reg.seq == PS_SEQ_RUN);
   assign dm_eff   = ps_resolve(req.dm_addr, st_reg.memory_pointer);
   assign dm_cur   = ps_read(st_reg, dm_eff);

   // Read-modify-write gives in-place bit set and clear on any writable location
   always_comb begin
      unique case (req.dm_op)
         PS_DM_BIT_SET:   dm_new = dm_cur | (8'h01 << req.dm_bit);
         PS_DM_BIT_CLEAR: dm_new = dm_cur & ~(8'h01 << req.dm_bit);
         default:         dm_new = req.dm_wdata;
      endcase
   end

   assign cnt_low_wr = (req.dm_op != PS_DM_NONE) && dm_eff[7] &&
                       (dm_eff[6:0] == `PS_ADDR_CNT_LOW);
   // Only a plain instruction boundary accepts an interrupt
   assign take_int = run_last && (req.cmd == PS_CMD_NONE) && !cnt_low_wr &&
                     (irq_req != 3'b000) && !stack_full;

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      st_next          = st_reg;
      st_next.ack      = 3'b000;
      st_next.int_exit = 1'b0;
      st_next.phase    = st_reg.phase + 2'h1;
      stk_push         = 1'b0;
      stk_pop          = 1'b0;
      if (last) begin
         unique case (st_reg.seq)
            PS_SEQ_RUN: begin
               st_next.ins = rom_data;
               st_next.program_counter = st_reg.program_counter + 11'h001;
               if (req.dm_op != PS_DM_NONE) begin
                  st_next = ps_write(st_next, dm_eff, dm_new);
               end
               unique case (req.cmd)
                  PS_CMD_SKIP: begin
                     // Prefetched word is dropped, the dummy fetches the one after it
                     st_next.program_counter = st_reg.program_counter + 11'h001;
                     st_next.seq = PS_SEQ_DUMMY;
                  end
                  PS_CMD_JUMP: begin
                     st_next.program_counter = st_reg.ins[10:0];
                     st_next.seq = PS_SEQ_DUMMY;
                  end
                  PS_CMD_CALL: begin
                     stk_push = 1'b1;
                     st_next.program_counter = st_reg.ins[10:0];
                     st_next.seq = PS_SEQ_DUMMY;
                  end
                  PS_CMD_SUB_EXIT, PS_CMD_INT_EXIT: begin
                     stk_pop = 1'b1;
                     st_next.program_counter = stk_top;
                     st_next.int_exit = (req.cmd == PS_CMD_INT_EXIT);
                     st_next.seq = PS_SEQ_DUMMY;
                  end
                  PS_CMD_TBL_CUR, PS_CMD_TBL_LAST: begin
                     // Prefetch kept; second cycle borrows the program memory
                     st_next.tbl_dst  = req.dm_addr;
                     st_next.tbl_last = (req.cmd == PS_CMD_TBL_LAST);
                     st_next.seq = PS_SEQ_TABLE;
                  end
                  default: begin
                     if (take_int) begin
                        // Prefetched word is dropped and its address saved
                        stk_push = 1'b1;
                        st_next.seq = PS_SEQ_DUMMY;
                        if (irq_req[0]) begin
                           st_next.program_counter = `PS_VEC_EXT;
                           st_next.ack = 3'b001;
                        end else if (irq_req[1]) begin
                           st_next.program_counter = `PS_VEC_TMR;
                           st_next.ack = 3'b010;
                        end else begin
                           st_next.program_counter = `PS_VEC_ADC;
                           st_next.ack = 3'b100;
                        end
                     end
                  end
               endcase
               if (cnt_low_wr) begin
                  st_next.program_counter = {st_reg.program_counter[10:8], dm_new};
                  st_next.seq = PS_SEQ_DUMMY;
               end
            end
            PS_SEQ_DUMMY: begin
               st_next.ins = rom_data;
               st_next.program_counter = st_reg.program_counter + 11'h001;
               st_next.seq = PS_SEQ_RUN;
            end
            PS_SEQ_TABLE: begin
               st_next = ps_write(st_next, ps_resolve(st_reg.tbl_dst, st_reg.memory_pointer),
                                  rom_data[7:0]);
               st_next.table_upper_result = rom_data[13:8];
               st_next.seq = PS_SEQ_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= RESET_STATE;
      end else begin
         st_reg <= st_next;
      end
   end

   // Stack lives outside the data map, no address reaches it
   ps_return_stack #(
      .DEPTH (STACK_DEPTH),
      .WIDTH (`PS_PC_WIDTH)
   ) u_stack (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .push      (stk_push),
      .pop       (stk_pop),
      .push_data (st_reg.program_counter),
      .top       (stk_top),
      .full      (stack_full)
   );

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      rom_addr = st_reg.program_counter;
      if (st_reg.seq == PS_SEQ_TABLE) begin
         rom_addr = {st_reg.tbl_last ? `PS_LAST_PAGE : st_reg.program_counter[10:8],
                     st_reg.table_address_pointer};
      end
   end

   assign exec_word       = st_reg.ins;
   assign exec_valid      = (st_reg.seq == PS_SEQ_RUN);
   assign exec_last       = last;
   assign dm_rdata        = dm_cur;
   assign irq_ack         = st_reg.ack;
   assign int_exit_pulse  = st_reg.int_exit;
   assign program_counter = st_reg.program_counter;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_reset_start: assert property ($fell(rst) |-> st_reg.program_counter == `PS_VEC_RESET &&
                                     st_reg.seq == PS_SEQ_DUMMY)
      else $error("counter not at reset vector");
   chk_pc_advance: assert property (run_last && req.cmd == PS_CMD_NONE && req.dm_op == PS_DM_NONE &&
                                    !take_int |=> program_counter == $past(program_counter) + 11'h001)
      else $error("counter did not advance by one");
   chk_skip_dummy: assert property (run_last && req.cmd == PS_CMD_SKIP && !cnt_low_wr |=>
                                    !exec_valid [*4] ##1 exec_valid)
      else $error("skip did not take one dummy cycle");
   chk_low_jump: assert property (run_last && cnt_low_wr |=>
                                  program_counter == {$past(program_counter[10:8]), $past(dm_new)})
      else $error("low byte write changed upper counter bits");
   chk_jump_load: assert property (run_last && req.cmd == PS_CMD_JUMP && !cnt_low_wr |=>
                                   program_counter == $past(exec_word[10:0]) && !exec_valid)
      else $error("jump target wrong");
   chk_call_return: assert property (run_last && req.cmd == PS_CMD_CALL && !cnt_low_wr |=>
                                     stk_top == $past(program_counter))
      else $error("call did not push return address");
   chk_pop_load: assert property (run_last && req.cmd == PS_CMD_SUB_EXIT && !cnt_low_wr |=>
                                  program_counter == $past(stk_top))
      else $error("return did not load stack top");
   chk_ext_vector: assert property (take_int && irq_req[0] |=>
                                    program_counter == `PS_VEC_EXT && irq_ack == 3'b001)
      else $error("external vector wrong");
   chk_full_hold: assert property (run_last && stack_full |=> irq_ack == 3'b000)
      else $error("interrupt taken on full stack");
   chk_table_two: assert property (run_last && req.cmd == PS_CMD_TBL_LAST && !cnt_low_wr |=>
                                   (st_reg.seq == PS_SEQ_TABLE && rom_addr[10:8] == `PS_LAST_PAGE) [*4]
                                   ##1 exec_valid)
      else $error("table read not two cycles");
   chk_ptr_top: assert property (req.dm_addr == `PS_ADDR_MEM_PTR |-> dm_rdata[7])
      else $error("pointer bit 7 not one");

   cov_call: cover property (run_last && req.cmd == PS_CMD_CALL && stack_full);
   cov_int: cover property (take_int);
   cov_table: cover property (run_last && req.cmd == PS_CMD_TBL_CUR);
   cov_skip: cover property (run_last && req.cmd == PS_CMD_SKIP);

endmodule // ps_sequencer
`default_nettype wire

// *** dv/ps_rom_model.sv ***
// Program memory model answering fetch and table addresses of the sequencer
`default_nettype none
module ps_rom_model (
   input  wire logic [10:0] rom_addr,
   output logic      [13:0] rom_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Word mixes address bits so a wrong fetch or table address shows at once
   assign rom_data = {rom_addr[2:0], rom_addr} ^ 14'h12a5;
endmodule // ps_rom_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench of the program sequencer with a program memory model
`default_nettype none
module tb_top import ps_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [10:0] rom_addr;
   logic [10:0] program_counter;
   logic [13:0] rom_data;
   logic [13:0] exec_word;
   logic        exec_valid;
   logic        exec_last;
   logic        int_exit_pulse;
   logic        stack_full;
   ps_req_type  req = '0;
   logic [7:0]  dm_rdata;
   logic [2:0]  irq_req = 3'h0;
   logic [2:0]  irq_ack;
   logic [10:0] bpc;
   logic [13:0] bw;
   logic [10:0] stk[$];
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          n_iexit = 0;
   int          seed = 17;

   ps_sequencer u_ps_sequencer (.sys_clk(sys_clk), .rst(rst), .rom_addr(rom_addr), .rom_data(rom_data),
      .exec_word(exec_word), .exec_valid(exec_valid), .exec_last(exec_last), .req(req),
      .dm_rdata(dm_rdata), .irq_req(irq_req), .irq_ack(irq_ack), .int_exit_pulse(int_exit_pulse),
      .stack_full(stack_full), .program_counter(program_counter));
   ps_rom_model u_ps_rom_model (.rom_addr(rom_addr), .rom_data(rom_data));

   always #4 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (int_exit_pulse === 1'b1) n_iexit++;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [13:0] exp_word(logic [10:0] a);
      return {a[2:0], a} ^ 14'h12a5;
   endfunction

   task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Request stands until the boundary edge takes it, then returns to idle
   task automatic op(ps_cmd_type c, ps_dm_op_type o = PS_DM_NONE, logic [6:0] a = 7'h00,
                     logic [7:0] d = 8'h00, logic [2:0] b = 3'h0, logic [2:0] irq = 3'h0);
      int k;
      k = 0;
      @(negedge sys_clk);
      req = '{c, o, a, b, d};
      irq_req = irq;
      while (!(exec_last === 1'b1 && exec_valid === 1'b1) && k < 40) begin
         @(negedge sys_clk);
         k++;
      end
      check(16'({exec_last, exec_valid}), 16'h0003, "boundary reached");
      check(exec_word, exp_word(program_counter - 11'd1), "fetched word");
      bpc = program_counter;
      bw = exec_word;
      @(negedge sys_clk);
      req = '{PS_CMD_NONE, PS_DM_NONE, a, 3'h0, 8'h00};
   endtask

   task automatic next_exec(logic [10:0] a, int gap);
      int k;
      k = 0;
      while (exec_valid !== 1'b1 && k < 40) begin
         @(negedge sys_clk);
         k++;
      end
      check(16'(k), 16'(gap), "dummy clocks");
      check(exec_word, exp_word(a), "next word");
      check(program_counter, a + 11'd1, "counter");
   endtask

   task automatic rd(logic [6:0] a, logic [7:0] exp, string what);
      @(negedge sys_clk);
      req.dm_addr = a;
      #1;
      check(dm_rdata, exp, what);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [7:0]  d;
      logic [7:0]  t;
      logic [6:0]  g;
      logic [10:0] r;
      logic [13:0] w;
      logic [2:0]  o;
      int          i;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      check(program_counter, 11'h000, "reset counter");
      rd(7'h01, 8'h80, "reset pointer");
      rd(7'h07, 8'h00, "reset table pointer");
      op(PS_CMD_NONE);
      check(bw, exp_word(11'h000), "first word");
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         g = 7'h40 | 7'(i * 9);
         op(PS_CMD_NONE, PS_DM_WRITE, 7'h01, d);
         rd(7'h01, {1'b1, d[6:0]}, "pointer");
         op(PS_CMD_NONE, PS_DM_WRITE, 7'h01, {1'b0, g});
         op(PS_CMD_NONE, PS_DM_WRITE, 7'h00, d);
         rd(g, d, "indirect write");
         op(PS_CMD_NONE, PS_DM_BIT_CLEAR, g, 8'h00, 3'(i));
         d[3'(i)] = 1'b0;
         rd(7'h00, d, "bit clear");
         op(PS_CMD_NONE, PS_DM_BIT_SET, g, 8'h00, 3'(i + 1));
         d[3'(i + 1)] = 1'b1;
         rd(g, d, "bit set");
         op(PS_CMD_NONE, PS_DM_WRITE, 7'h05, ~d);
         rd(7'h05, ~d, "working register");
         op(PS_CMD_NONE, PS_DM_WRITE, 7'h07, d);
         rd(7'h07, d, "table pointer");
      end
      op(PS_CMD_NONE, PS_DM_WRITE, 7'h08, 8'h5a);
      rd(7'h08, 8'h00, "upper result write");
      op(PS_CMD_NONE, PS_DM_WRITE, 7'h3f, 8'h5a);
      rd(7'h3f, 8'h00, "unused location");
      op(PS_CMD_NONE, PS_DM_WRITE, 7'h01, 8'h00);
      op(PS_CMD_NONE, PS_DM_WRITE, 7'h00, 8'h77);
      rd(7'h00, 8'h00, "self indirect");
      // Mixed transfers with random data, table pointer value 8'hff included
      for (i = 0; i < 30; i++) begin
         d = 8'($random(seed));
         t = (i < 4) ? {8{i[0]}} : 8'($random(seed));
         g = 7'h40 | 7'(d);
         case (i % 5)
            0: begin
               op(PS_CMD_NONE, PS_DM_WRITE, 7'h05, d);
               op(PS_CMD_JUMP);
               // Request standing over the dummy boundary must be ignored
               @(negedge sys_clk);
               req = '{PS_CMD_CALL, PS_DM_WRITE, 7'h05, 3'h0, ~d};
               next_exec(bw[10:0], 3);
               req = '{PS_CMD_NONE, PS_DM_NONE, 7'h05, 3'h0, 8'h00};
               rd(7'h05, d, "dummy cycle");
            end
            1: begin
               op(PS_CMD_SKIP);
               next_exec(bpc + 11'd1, 4);
            end
            2: begin
               op(PS_CMD_NONE, PS_DM_WRITE, 7'h06, d);
               next_exec({bpc[10:8], d}, 4);
               rd(7'h06, d + 8'd1, "counter low byte");
            end
            default: begin
               op(PS_CMD_NONE, PS_DM_WRITE, 7'h07, t);
               op(ps_cmd_type'((i % 5 == 3) ? PS_CMD_TBL_LAST : PS_CMD_TBL_CUR), PS_DM_NONE, g);
               // Counter already points past the kept prefetch
               r = bpc + 11'd1;
               r = {(i % 5 == 3) ? 3'h7 : r[10:8], t};
               w = exp_word(r);
               check(rom_addr, r, "table address");
               next_exec(bpc, 4);
               rd(g, w[7:0], "table low byte");
               rd(7'h08, {2'b00, w[13:8]}, "table upper");
            end
         endcase
      end

      // ****************************************
      // Interrupts and return stack
      // ****************************************
      for (i = 1; i < 8; i++) begin
         o = 3'(i & -i);
         r = (o == 3'b001) ? 11'h004 : (o == 3'b010) ? 11'h008 : 11'h00c;
         op(PS_CMD_NONE, PS_DM_NONE, 7'h00, 8'h00, 3'h0, 3'(i));
         irq_req = 3'h0;
         t = {5'h00, irq_ack};
         check(t, {5'h00, o}, "acknowledge");
         check(program_counter, r, "vector");
         w = {3'h0, bpc};
         next_exec(r, 4);
         op(PS_CMD_INT_EXIT);
         next_exec(w[10:0], 4);
         check(16'(n_iexit), 16'(i), "exit pulse");
      end
      for (i = 0; i < 7; i++) begin
         op(PS_CMD_CALL);
         stk.push_back(bpc);
         if (stk.size() > 6) stk.pop_front();
         next_exec(bw[10:0], 4);
      end
      check(stack_full, 1'b1, "stack full");
      rd(7'h04, 8'h00, "stack hidden");
      op(PS_CMD_NONE, PS_DM_NONE, 7'h00, 8'h00, 3'h0, 3'b010);
      check(irq_ack, 3'b000, "held while full");
      op(PS_CMD_SUB_EXIT, PS_DM_NONE, 7'h00, 8'h00, 3'h0, 3'b010);
      next_exec(stk.pop_back(), 4);
      op(PS_CMD_NONE, PS_DM_NONE, 7'h00, 8'h00, 3'h0, 3'b010);
      irq_req = 3'h0;
      check(irq_ack, 3'b010, "served after pop");
      stk.push_back(bpc);
      next_exec(11'h008, 4);
      while (stk.size() > 0) begin
         op(ps_cmd_type'(stk.size() == 6 ? PS_CMD_INT_EXIT : PS_CMD_SUB_EXIT));
         next_exec(stk.pop_back(), 4);
      end
      check(stack_full, 1'b0, "stack drained");
      conclude();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      $display("unexpected at %0t: run did not finish in time", $time);
      conclude();
   end
endmodule // tb_top
`default_nettype wire
